//--- design/anr_pkg.sv
// Shared constants and types for the auto-negotiation base page resolution block.
package anr_pkg;

  localparam int          SEL_W          = 5;
  localparam int          ABIL_W         = 8;
  localparam int          PAGE_W         = 13;
  localparam int          CODE_W         = 11;
  localparam int          CNT_W          = 4;
  localparam int          SEL_LSB        = 0;
  localparam int          ABIL_LSB       = 5;
  localparam int          PRIO_N         = 10;
  localparam int          STD_N          = 9;

  localparam logic [4:0]  SEL_IEEE8023   = 5'h01;
  localparam logic [10:0] MSG_RSVD_LOW   = 11'h000;
  localparam logic [10:0] MSG_RSVD_HIGH  = 11'h7ff;
  localparam logic [3:0]  CNT_ZERO       = 4'h0;
  localparam logic [3:0]  CNT_ONE        = 4'h1;

  // Positions inside the technology ability bits.
  localparam int          AB_10T         = 0;
  localparam int          AB_10T_FD      = 1;
  localparam int          AB_TX          = 2;
  localparam int          AB_TX_FD       = 3;
  localparam int          AB_T4          = 4;
  localparam int          AB_PAUSE       = 5;
  localparam int          AB_ASM_DIR     = 6;
  localparam int          AB_RSVD7       = 7;

  // Slots of the standard priority list, highest first.
  localparam int          PR_1000_FD     = 0;
  localparam int          PR_1000        = 1;
  localparam int          PR_T2_FD       = 2;
  localparam int          PR_TX_FD       = 3;
  localparam int          PR_T2          = 4;
  localparam int          PR_T4          = 5;
  localparam int          PR_TX          = 6;
  localparam int          PR_10_FD       = 7;
  localparam int          PR_10          = 8;

  typedef enum logic [3:0] {
    TECH_NONE, TECH_1000_FD, TECH_1000, TECH_T2_FD, TECH_TX_FD,
    TECH_T2, TECH_T4, TECH_TX, TECH_10_FD, TECH_10, TECH_VENDOR
  } anr_tech_t;

  typedef struct packed {
    logic asm_dir;
    logic pause;
    logic t4;
    logic tx_fd;
    logic tx;
    logic t10_fd;
    logic t10;
  } anr_base_abil_t;

  // Abilities learned outside the base page, through next page exchange.
  typedef struct packed {
    logic g1000_fd;
    logic g1000;
    logic t2_fd;
    logic t2;
    logic vendor;
  } anr_ext_abil_t;

  typedef struct packed {
    logic              is_msg;
    logic [CODE_W-1:0] code;
  } anr_np_page_t;

  typedef enum logic [1:0] {NP_IDLE, NP_MSG, NP_UNF} anr_np_state_t;

endpackage

//--- design/anr_base_page_res.sv
// Base page encoder, priority resolution, pause resolution and next page ordering.
// How it works
// - Selector field always carries value 00001.
// - Selector is constant; reserved codes never sent.
// - Ability bits sit at base page D5..D12.
// - A0..A4 map to the five legacy technologies.
// - Reserved ability bit A7 always sent zero.
// - A5/A6 only with MAC control pause support.
// - A5 is PAUSE, A6 is ASM_DIR.
// - Pause transmit and receive enabled separately.
// - Highest common technology chosen by fixed list.
// - Vendor technology inserts anywhere, standard order kept.
// - Pause enabled only for full duplex result.
// - Pause bits never influence technology choice.
// - Both PAUSE set enables transmit and receive.
// - Local 01, partner 11: transmit only.
// - Local 11, partner 01: receive only.
// - All other pause combinations disable both.
// - Message page precedes each unformatted page series.
`timescale 1ns/100ps

module anr_base_page_res (
  input  wire logic                          sys_clk,
  input  wire logic                          arst_n,
  input  wire anr_pkg::anr_base_abil_t       local_abil,
  input  wire anr_pkg::anr_ext_abil_t        local_ext,
  input  wire logic                          mac_ctrl_pause_impl,
  input  wire logic [anr_pkg::PAGE_W-1:0]    partner_base_page,
  input  wire anr_pkg::anr_ext_abil_t        partner_ext,
  input  wire logic [3:0]                    vendor_slot,
  input  wire logic                          vendor_full_duplex,
  input  wire logic                          an_complete,
  input  wire logic                          an_restart,
  input  wire logic                          np_start,
  input  wire logic [anr_pkg::CODE_W-1:0]    np_msg_code,
  input  wire logic [anr_pkg::CNT_W-1:0]     np_unf_total,
  input  wire logic [anr_pkg::CODE_W-1:0]    np_unf_code,
  input  wire logic                          np_page_taken,
  output logic [anr_pkg::PAGE_W-1:0]         base_page_q,
  output anr_pkg::anr_tech_t                 resolved_tech_q,
  output logic                               resolved_valid_q,
  output logic                               pause_tx_en_q,
  output logic                               pause_rx_en_q,
  output anr_pkg::anr_np_page_t              np_page_q,
  output logic                               np_page_valid_q,
  output logic                               np_busy_q
);
  import anr_pkg::*;

  logic                 rst_sync1_q;
  logic                 rst_sync2_q;
  logic                 rst_n;
  logic [ABIL_W-1:0]    abil_d;
  logic [ABIL_W-1:0]    p_abil;
  logic [SEL_W-1:0]     p_sel;
  logic                 p_ok;
  logic [STD_N-1:0]     loc_std;
  logic [STD_N-1:0]     par_std;
  logic [STD_N-1:0]     com_std;
  logic                 com_vendor;
  anr_tech_t            tech_d;
  logic                 fd_d;
  logic                 l_pause;
  logic                 l_asm;
  logic                 r_pause;
  logic                 r_asm;
  logic                 tx_d;
  logic                 rx_d;
  anr_np_state_t        np_state_q;
  logic [CNT_W-1:0]     np_left_q;
  logic                 np_code_ok;
  logic                 np_open;
  logic                 np_next;
  logic                 np_close;

  // Reset is released through two flops so all logic leaves reset on one edge.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end
  assign rst_n = rst_sync2_q;

  // Local ability encoding.
  always_comb begin
    abil_d             = '0;
    abil_d[AB_10T]     = local_abil.t10;
    abil_d[AB_10T_FD]  = local_abil.t10_fd;
    abil_d[AB_TX]      = local_abil.tx;
    abil_d[AB_TX_FD]   = local_abil.tx_fd;
    abil_d[AB_T4]      = local_abil.t4;
    // Pause bits are masked rather than trusted, so a station without
    // the MAC control sublayer can never promise flow control.
    abil_d[AB_PAUSE]   = local_abil.pause & mac_ctrl_pause_impl;
    abil_d[AB_ASM_DIR] = local_abil.asm_dir & mac_ctrl_pause_impl;
    abil_d[AB_RSVD7]   = 1'b0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      base_page_q <= '0;
    end else begin
      base_page_q[SEL_LSB +: SEL_W]   <= SEL_IEEE8023;
      base_page_q[ABIL_LSB +: ABIL_W] <= abil_d;
    end
  end

  // Partner decode; a foreign selector leaves nothing in common.
  assign p_sel = partner_base_page[SEL_LSB +: SEL_W];
  assign p_abil = partner_base_page[ABIL_LSB +: ABIL_W];
  assign p_ok = (p_sel == SEL_IEEE8023);

  // Standard technologies in priority order; pause bits are not used here.
  always_comb begin
    loc_std             = '0;
    loc_std[PR_1000_FD] = local_ext.g1000_fd;
    loc_std[PR_1000]    = local_ext.g1000;
    loc_std[PR_T2_FD]   = local_ext.t2_fd;
    loc_std[PR_TX_FD]   = local_abil.tx_fd;
    loc_std[PR_T2]      = local_ext.t2;
    loc_std[PR_T4]      = local_abil.t4;
    loc_std[PR_TX]      = local_abil.tx;
    loc_std[PR_10_FD]   = local_abil.t10_fd;
    loc_std[PR_10]      = local_abil.t10;
    par_std             = '0;
    par_std[PR_1000_FD] = partner_ext.g1000_fd;
    par_std[PR_1000]    = partner_ext.g1000;
    par_std[PR_T2_FD]   = partner_ext.t2_fd;
    par_std[PR_TX_FD]   = p_abil[AB_TX_FD];
    par_std[PR_T2]      = partner_ext.t2;
    par_std[PR_T4]      = p_abil[AB_T4];
    par_std[PR_TX]      = p_abil[AB_TX];
    par_std[PR_10_FD]   = p_abil[AB_10T_FD];
    par_std[PR_10]      = p_abil[AB_10T];
  end

  assign com_std = p_ok ? (loc_std & par_std) : '0;
  assign com_vendor = p_ok & local_ext.vendor & partner_ext.vendor;

  function automatic anr_tech_t std_tech(input int idx);
    anr_tech_t t;
    t = TECH_NONE;
    unique case (idx)
      PR_1000_FD: t = TECH_1000_FD;
      PR_1000:    t = TECH_1000;
      PR_T2_FD:   t = TECH_T2_FD;
      PR_TX_FD:   t = TECH_TX_FD;
      PR_T2:      t = TECH_T2;
      PR_T4:      t = TECH_T4;
      PR_TX:      t = TECH_TX;
      PR_10_FD:   t = TECH_10_FD;
      PR_10:      t = TECH_10;
      default:    t = TECH_NONE;
    endcase
    return t;
  endfunction

  // Walk from the highest priority downward; the vendor entry is checked
  // just ahead of the standard slot it is placed before, so standard order
  // never moves. A slot at or past the list end puts it last.
  always_comb begin
    logic found;
    found  = 1'b0;
    tech_d = TECH_NONE;
    for (int i = 0; i < PRIO_N; i++) begin
      if (!found && com_vendor && (vendor_slot == 4'(i))) begin
        tech_d = TECH_VENDOR;
        found  = 1'b1;
      end
      if (!found && (i < STD_N) && com_std[i]) begin
        tech_d = std_tech(i);
        found  = 1'b1;
      end
    end
    if (!found && com_vendor) begin
      tech_d = TECH_VENDOR;
    end
  end

  always_comb begin
    unique case (tech_d)
      TECH_1000_FD, TECH_T2_FD, TECH_TX_FD, TECH_10_FD: fd_d = 1'b1;
      TECH_VENDOR: fd_d = vendor_full_duplex;
      default:     fd_d = 1'b0;
    endcase
  end

  // Pause resolution, independent outputs for each direction.
  assign l_pause = abil_d[AB_PAUSE];
  assign l_asm   = abil_d[AB_ASM_DIR];
  assign r_pause = p_ok & p_abil[AB_PAUSE];
  assign r_asm   = p_ok & p_abil[AB_ASM_DIR];

  always_comb begin
    tx_d = 1'b0;
    rx_d = 1'b0;
    if (fd_d) begin
      if (l_pause && r_pause) begin
        tx_d = 1'b1;
        rx_d = 1'b1;
      end else if (!l_pause && l_asm && r_pause && r_asm) begin
        tx_d = 1'b1;
      end else if (l_pause && l_asm && !r_pause && r_asm) begin
        rx_d = 1'b1;
      end
    end
  end

  // Results are snapshots; inputs moving later do not disturb the link.
  // A restart in the same cycle as completion wins, since it voids the exchange.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resolved_tech_q  <= TECH_NONE;
      resolved_valid_q <= 1'b0;
    end else if (an_restart) begin
      resolved_tech_q  <= TECH_NONE;
      resolved_valid_q <= 1'b0;
    end else if (an_complete && !resolved_valid_q) begin
      resolved_tech_q  <= tech_d;
      resolved_valid_q <= 1'b1;
    end
  end

  // Pause enables are latched on the same edge as the technology they belong to.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pause_tx_en_q <= 1'b0;
      pause_rx_en_q <= 1'b0;
    end else if (an_restart) begin
      pause_tx_en_q <= 1'b0;
      pause_rx_en_q <= 1'b0;
    end else if (an_complete && !resolved_valid_q) begin
      pause_tx_en_q <= tx_d;
      pause_rx_en_q <= rx_d;
    end
  end

  // Next page ordering: a series always opens with its message page.
  // Reserved message codes are refused so they never reach the wire.
  assign np_code_ok = (np_msg_code != MSG_RSVD_LOW) && (np_msg_code != MSG_RSVD_HIGH);
  assign np_open    = (np_state_q == NP_IDLE) && np_start && np_code_ok;
  assign np_next    = (np_state_q != NP_IDLE) && np_page_taken && (np_left_q != CNT_ZERO);
  assign np_close   = (np_state_q != NP_IDLE) && np_page_taken && (np_left_q == CNT_ZERO);

  // Sequencer state and the count of unformatted pages still owed.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_state_q <= NP_IDLE;
      np_left_q  <= CNT_ZERO;
    end else if (an_restart) begin
      np_state_q <= NP_IDLE;
      np_left_q  <= CNT_ZERO;
    end else begin
      unique case (np_state_q)
        NP_IDLE: begin
          if (np_open) begin
            np_state_q <= NP_MSG;
            np_left_q  <= np_unf_total;
          end
        end
        NP_MSG, NP_UNF: begin
          if (np_close) begin
            np_state_q <= NP_IDLE;
          end else if (np_next) begin
            np_state_q <= NP_UNF;
            np_left_q  <= np_left_q - CNT_ONE;
          end
        end
        // The unused fourth state code is steered back to idle.
        default: begin
          np_state_q <= NP_IDLE;
          np_left_q  <= CNT_ZERO;
        end
      endcase
    end
  end

  // Page contents; a restart keeps the last page but drops its valid flag.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_page_q <= '0;
    end else if (!an_restart && np_open) begin
      np_page_q.is_msg <= 1'b1;
      np_page_q.code   <= np_msg_code;
    end else if (!an_restart && np_next) begin
      np_page_q.is_msg <= 1'b0;
      np_page_q.code   <= np_unf_code;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      np_page_valid_q <= 1'b0;
      np_busy_q       <= 1'b0;
    end else if (an_restart || np_close) begin
      np_page_valid_q <= 1'b0;
      np_busy_q       <= 1'b0;
    end else if (np_open) begin
      np_page_valid_q <= 1'b1;
      np_busy_q       <= 1'b1;
    end
  end

endmodule

//--- sim/anr_partner.sv
// Link partner model that builds the partner base page from its abilities.
`timescale 1ns/100ps
module anr_partner (
  input  wire anr_pkg::anr_base_abil_t abil,
  input  wire logic [4:0]              sel,
  output logic [12:0]                  page
);
  import anr_pkg::*;
  // The partner keeps its reserved bit at zero, as any compliant station does.
  assign page = {1'b0, abil, sel};
endmodule

//--- sim/anr_chk.sv
// Checker with the port level assertions of the resolution block.
`timescale 1ns/100ps
module anr_chk (
  input wire logic                  sys_clk,
  input wire logic                  arst_n,
  input wire anr_pkg::anr_base_abil_t local_abil,
  input wire logic                  mac_ctrl_pause_impl,
  input wire logic                  vendor_full_duplex,
  input wire logic [12:0]           partner_base_page,
  input wire logic                  an_complete,
  input wire logic                  an_restart,
  input wire logic [12:0]           base_page_q,
  input wire anr_pkg::anr_tech_t    resolved_tech_q,
  input wire logic                  resolved_valid_q,
  input wire logic                  pause_tx_en_q,
  input wire logic                  pause_rx_en_q,
  input wire anr_pkg::anr_np_page_t np_page_q,
  input wire logic                  np_page_valid_q,
  input wire logic                  np_busy_q
);
  import anr_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  wire logic fd = resolved_tech_q inside {TECH_1000_FD, TECH_T2_FD, TECH_TX_FD, TECH_10_FD} ||
                  (resolved_tech_q == TECH_VENDOR && vendor_full_duplex);
  sel_code_a: assert property (|base_page_q |-> base_page_q[4:0] == SEL_IEEE8023)
    else $error("selector field wrong");
  rsvd_zero_a: assert property (base_page_q[12] == 1'b0)
    else $error("reserved ability bit set");
  abil_map_a: assert property (|base_page_q |-> base_page_q[9:5] == $past(local_abil[4:0]))
    else $error("ability bits misplaced");
  pause_gate_a: assert property (!mac_ctrl_pause_impl ##1 !mac_ctrl_pause_impl
    |-> base_page_q[11:10] == 2'b00) else $error("pause bits sent without support");
  pause_fd_a: assert property (pause_tx_en_q || pause_rx_en_q |-> fd)
    else $error("pause enabled on half duplex");
  tx_only_a: assert property (pause_tx_en_q && !pause_rx_en_q |-> base_page_q[11:10] == 2'b10
    && partner_base_page[11:10] == 2'b11) else $error("transmit only pause wrong");
  rx_only_a: assert property (pause_rx_en_q && !pause_tx_en_q |-> base_page_q[11:10] == 2'b11
    && partner_base_page[11:10] == 2'b10) else $error("receive only pause wrong");
  both_on_a: assert property (resolved_valid_q && fd && base_page_q[10] && partner_base_page[10]
    |-> pause_tx_en_q && pause_rx_en_q) else $error("symmetric pause not enabled");
  result_hold_a: assert property (resolved_valid_q && !an_restart |=> resolved_valid_q
    && $stable(resolved_tech_q) && $stable(pause_tx_en_q)) else $error("result not held");
  restart_clr_a: assert property (an_restart |=> !resolved_valid_q
    && resolved_tech_q == TECH_NONE && !pause_tx_en_q && !pause_rx_en_q)
    else $error("restart did not clear");
  resolve_lat_a: assert property (an_complete && !an_restart && !resolved_valid_q
    |-> ##[1:2] resolved_valid_q) else $error("result not produced");
  msg_first_a: assert property ($rose(np_busy_q) |-> np_page_valid_q && np_page_q.is_msg)
    else $error("series did not open with message page");
  both_c: cover property (pause_tx_en_q && pause_rx_en_q);
  rx_c: cover property (pause_rx_en_q && !pause_tx_en_q);
  np_c: cover property ($fell(np_busy_q));
endmodule

//--- sim/anr_base_page_res_tb.sv
// Self-checking testbench of the base page resolution block.
`timescale 1ns/100ps
module anr_base_page_res_tb;
  import anr_pkg::*;
  logic sys_clk = 0, arst_n = 0, mac_pause = 0, v_fd = 1, an_done = 0, an_rst = 0;
  logic np_go = 0, np_take = 0, valid, ptx, prx, npv, npb;
  logic [4:0] p_sel = 5'h01;
  logic [3:0] v_slot = 4'h9, np_tot = 4'h1;
  logic [10:0] np_code = 11'h005, np_ucode = 11'h007;
  logic [12:0] p_page, page;
  anr_base_abil_t loc_abil = '0, p_abil = '0;
  anr_ext_abil_t loc_ext = 5'h1e, p_ext = '0;
  anr_tech_t tech;
  anr_np_page_t npg;
  int errors = 0, n_tests = 0;
  anr_partner lp (.abil(p_abil), .sel(p_sel), .page(p_page));
  anr_base_page_res dut (.sys_clk(sys_clk), .arst_n(arst_n), .local_abil(loc_abil),
    .local_ext(loc_ext), .mac_ctrl_pause_impl(mac_pause), .partner_base_page(p_page),
    .partner_ext(p_ext), .vendor_slot(v_slot), .vendor_full_duplex(v_fd),
    .an_complete(an_done), .an_restart(an_rst), .np_start(np_go), .np_msg_code(np_code),
    .np_unf_total(np_tot), .np_unf_code(np_ucode), .np_page_taken(np_take),
    .base_page_q(page), .resolved_tech_q(tech), .resolved_valid_q(valid),
    .pause_tx_en_q(ptx), .pause_rx_en_q(prx), .np_page_q(npg), .np_page_valid_q(npv),
    .np_busy_q(npb));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic chk(input string s, input logic [12:0] e, input logic [12:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_tech(input anr_tech_t e, input anr_tech_t g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("wrong value tech expected %0d seen %0d", e, g);
    end
  endtask
  // Restart first with old inputs, so no output pairs with a half-changed partner page.
  task automatic res(input logic [6:0] pa, input logic [4:0] pe);
    an_rst = 1;
    @(negedge sys_clk);
    an_rst = 0;
    p_abil = pa;
    p_ext = pe;
    @(negedge sys_clk);
    an_done = 1;
    @(negedge sys_clk);
    an_done = 0;
    for (int i = 0; i < 4 && valid !== 1'b1; i++) @(negedge sys_clk);
  endtask
  task automatic t_page;
    loc_abil = 7'h7f;
    repeat (2) @(negedge sys_clk);
    chk("page", 13'h03e1, page);
    mac_pause = 1;
    repeat (2) @(negedge sys_clk);
    chk("page", 13'h0fe1, page);
  endtask
  task automatic t_prio;
    logic [4:0] pb [9] = '{5'h01, 5'h01, 5'h01, 5'h08, 5'h10, 5'h14, 5'h06, 5'h03, 5'h01};
    logic [4:0] pe [9] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h02, 5'h00, 5'h00, 5'h00, 5'h00};
    loc_abil = 7'h1f;
    for (int i = 0; i < 9; i++) begin
      res({2'b00, pb[i]}, pe[i]);
      chk_tech(anr_tech_t'(i + 1), tech);
    end
  endtask
  task automatic t_pause;
    logic lp, la, rp, ra;
    for (int k = 0; k < 16; k++) begin
      {lp, la, rp, ra} = k[3:0];
      loc_abil = {la, lp, 5'h1f};
      res({ra, rp, 5'h0c}, 5'h00);
      chk_tech(TECH_TX_FD, tech);
      chk("tx", lp & rp | !lp & la & rp & ra, ptx);
      chk("rx", lp & rp | lp & la & !rp & ra, prx);
    end
    loc_abil = 7'h7f;
    res(7'h70, 5'h00);
    chk("half", 13'h0000, {ptx, prx});
  endtask
  // Duplex of the vendor entry only changes while a non-vendor result is held.
  task automatic t_other;
    loc_abil = 7'h7f;
    loc_ext = 5'h1f;
    v_slot = 4'h3;
    res(7'h68, 5'h01);
    chk_tech(TECH_VENDOR, tech);
    chk("vfd", 13'h0003, {ptx, prx});
    v_slot = 4'h9;
    res(7'h08, 5'h01);
    chk_tech(TECH_TX_FD, tech);
    v_fd = 0;
    v_slot = 4'h3;
    res(7'h68, 5'h01);
    chk("vhd", 13'h0000, {ptx, prx});
    p_sel = 5'h02;
    res(7'h01, 5'h00);
    chk_tech(TECH_NONE, tech);
    chk("valid", 13'h0001, valid);
    p_sel = 5'h01;
    res(7'h08, 5'h00);
    p_abil = 7'h01;
    an_done = 1;
    repeat (3) @(negedge sys_clk);
    an_done = 0;
    chk_tech(TECH_TX_FD, tech);
    an_rst = 1;
    @(negedge sys_clk);
    an_rst = 0;
    @(negedge sys_clk);
    chk_tech(TECH_NONE, tech);
    chk("valid", 13'h0000, valid);
  endtask
  task automatic t_np;
    np_code = 11'h7ff;
    np_go = 1;
    @(negedge sys_clk);
    np_go = 0;
    repeat (2) @(negedge sys_clk);
    chk("busy", 13'h0000, npb);
    np_code = 11'h005;
    np_go = 1;
    @(negedge sys_clk);
    np_go = 0;
    for (int i = 0; i < 4 && npv !== 1'b1; i++) @(negedge sys_clk);
    chk("msg", 13'h0805, npg);
    np_take = 1;
    @(negedge sys_clk);
    np_take = 0;
    for (int i = 0; i < 4 && npg.is_msg !== 1'b0; i++) @(negedge sys_clk);
    chk("unf", 13'h0007, npg);
    np_take = 1;
    @(negedge sys_clk);
    np_take = 0;
    for (int i = 0; i < 4 && npb !== 1'b0; i++) @(negedge sys_clk);
    chk("end", 13'h0000, {npv, npb});
  endtask
  task automatic test_done;
    if (errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge sys_clk);
    arst_n = 1;
    repeat (4) @(negedge sys_clk);
    t_page();
    t_prio();
    t_pause();
    t_other();
    t_np();
    test_done();
  end
  initial begin
    #100000;
    errors++;
    test_done();
  end
endmodule
bind anr_base_page_res anr_chk chk_i (
  .sys_clk(sys_clk), .arst_n(arst_n), .local_abil(local_abil),
  .mac_ctrl_pause_impl(mac_ctrl_pause_impl), .vendor_full_duplex(vendor_full_duplex),
  .partner_base_page(partner_base_page), .an_complete(an_complete),
  .an_restart(an_restart), .base_page_q(base_page_q), .resolved_tech_q(resolved_tech_q),
  .resolved_valid_q(resolved_valid_q), .pause_tx_en_q(pause_tx_en_q),
  .pause_rx_en_q(pause_rx_en_q), .np_page_q(np_page_q), .np_page_valid_q(np_page_valid_q),
  .np_busy_q(np_busy_q)
);
